/* lchp_fifo.sv */
// Single-clock word FIFO with valid/ready on both sides
`timescale 1ns/1ns
`default_nettype none
module lchp_fifo #(
  parameter int W = 8,
  parameter int DEPTH = 8
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rstn,
  // Fill side
  input wire logic [W-1:0] i_in_data,
  input wire logic i_in_valid,
  output logic o_in_ready,
  // Drain side
  output logic [W-1:0] o_out_data,
  output logic o_out_valid,
  input wire logic i_out_ready
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);
  logic [W-1:0] mem_r [DEPTH];
  logic [W-1:0] mem_nxt [DEPTH];
  logic [AW-1:0] wp_r, wp_nxt, rp_r, rp_nxt;
  logic [CW-1:0] cnt_r, cnt_nxt;
  logic push, pop;

  assign o_in_ready = cnt_r != CW'(DEPTH);
  assign o_out_valid = cnt_r != '0;
  assign o_out_data = mem_r[rp_r];
  assign push = i_in_valid && o_in_ready;
  assign pop = o_out_valid && i_out_ready;

  always_comb begin
    mem_nxt = mem_r;
    wp_nxt = wp_r;
    rp_nxt = rp_r;
    if (push) begin
      mem_nxt[wp_r] = i_in_data;
      wp_nxt = (wp_r == AW'(DEPTH - 1)) ? '0 : AW'(wp_r + 1'b1);
    end
    if (pop) begin
      rp_nxt = (rp_r == AW'(DEPTH - 1)) ? '0 : AW'(rp_r + 1'b1);
    end
    cnt_nxt = CW'(cnt_r + CW'(push) - CW'(pop));
  end

  always_ff @(posedge i_clk) begin
    mem_r <= mem_nxt;
    if (!i_rstn) begin
      wp_r <= '0;
      rp_r <= '0;
      cnt_r <= '0;
    end else begin
      wp_r <= wp_nxt;
      rp_r <= rp_nxt;
      cnt_r <= cnt_nxt;
    end
  end
endmodule
`default_nettype wire

/* lchp_host_port.sv */
// Host bus port with shared-memory transmit and receive FIFOs
`timescale 1ns/1ns
`default_nettype none
`include "lchp_regs.svh"
module lchp_host_port #(
  parameter int MEM_WORDS = `LCHP_MEM_WORDS,
  parameter int RX_BUF_DEPTH = `LCHP_RX_BUF_DEPTH
) (
  // Clock and resets
  input wire logic i_core_clk,
  input wire logic i_rstn,
  input wire logic i_por_n,
  // Host bus
  input wire logic i_cs_n,
  input wire logic i_wr_n,
  input wire logic [0:7] i_host_address_lines,
  input wire logic [0:31] i_host_data,
  output logic [0:31] o_host_data,
  output logic o_host_data_oe,
  output logic o_cycle_ack_n,
  output logic o_int_n,
  // Link side
  input wire logic i_link_clk,
  input wire logic i_link_rstn,
  input wire lchp_pkg::lchp_rx_word_t i_rx_word,
  input wire logic i_rx_valid,
  output logic o_rx_ready,
  output lchp_pkg::lchp_tx_word_t o_tx_word,
  output logic o_tx_valid,
  input wire logic i_tx_ready
);
  import lchp_pkg::*;
  localparam int AW = $clog2(MEM_WORDS);
  localparam int CW = AW + 1;
  localparam int RXW = $bits(lchp_rx_word_t);
  localparam int TXW = $bits(lchp_tx_word_t);

  logic [7:0] addr;
  logic [31:0] wdata;
  logic was_cs_r, is_fifo, take, hw, hr;
  logic [31:0] fc_r, fc_nxt;
  logic [`LCHP_LC_W-1:0] lc_r, lc_nxt;
  logic [`LCHP_INT_W-1:0] ist_r, ist_nxt, imask_r, imask_nxt, iset, iclr;
  logic ack_r, oe_r;
  logic [31:0] rd_r, rd_nxt;
  logic clr;
  logic [CW-1:0] atf_size, itf_size, blk, grf_size;
  logic [CW:0] used;
  logic [CW-1:0] atf_wp_r, atf_rp_r, atf_cnt_r, itf_wp_r, itf_rp_r, itf_cnt_r;
  logic [CW-1:0] grf_wp_r, grf_rp_r, grf_tot_r, grf_vis_r, grf_pend_r;
  logic [CW-1:0] atf_wp_n, atf_rp_n, atf_cnt_n, itf_wp_n, itf_rp_n, itf_cnt_n;
  logic [CW-1:0] grf_wp_n, grf_rp_n, grf_tot_n, grf_vis_n, grf_pend_n;
  logic atf_full, itf_full, atf_push, itf_push, grf_pop, grf_space;
  logic [31:0] mem_r [MEM_WORDS];
  logic [31:0] mem_nxt [MEM_WORDS];
  logic [AW-1:0] tx_raddr, grf_raddr, grf_waddr;
  logic sel_iso, sel_async, tx_valid, tx_ready, tx_pop;
  lchp_tx_word_t tx_word;
  lchp_rx_word_t rxx_data, rxq;
  logic rxx_valid, rxx_ready, rxq_valid, rxq_ready;
  lchp_wr_state_t wst_r, wst_nxt;
  logic grf_we, commit, rx_en, blk_mode;
  logic [31:0] grf_wd;
  logic [31:0] atf_stat, itf_stat, grf_stat;

  // Host bus decode
  assign addr = i_host_address_lines;
  assign wdata = i_host_data;
  assign is_fifo = addr == `LCHP_OFS_ATF_DATA || addr == `LCHP_OFS_ITF_DATA
                   || addr == `LCHP_OFS_GRF_DATA;
  // Registers once per strobe, FIFO data every cycle of the strobe
  assign take = !i_cs_n && (is_fifo || !was_cs_r);
  assign hw = take && !i_wr_n;
  assign hr = take && i_wr_n;
  assign o_cycle_ack_n = !ack_r;
  assign o_host_data = rd_r;
  assign o_host_data_oe = oe_r;

  // Memory partition
  assign atf_size = fc_r[`LCHP_FC_ATF_LSB +: CW];
  assign itf_size = fc_r[`LCHP_FC_ITF_LSB +: CW];
  assign blk = fc_r[`LCHP_FC_BLK_LSB +: CW];
  assign used = {1'b0, atf_size} + {1'b0, itf_size};
  assign grf_size = (used > (CW + 1)'(MEM_WORDS)) ? '0
                    : CW'((CW + 1)'(MEM_WORDS) - used);
  assign clr = hw && addr == `LCHP_OFS_FIFO_CTRL && wdata[`LCHP_FC_CLR_BIT];

  assign atf_full = atf_cnt_r == atf_size;
  assign itf_full = itf_cnt_r == itf_size;
  assign atf_push = hw && addr == `LCHP_OFS_ATF_DATA && !atf_full;
  assign itf_push = hw && addr == `LCHP_OFS_ITF_DATA && !itf_full;
  assign grf_pop = hr && addr == `LCHP_OFS_GRF_DATA && grf_vis_r != '0;
  assign grf_space = grf_tot_r < grf_size;
  assign grf_raddr = AW'(used[CW-1:0] + grf_rp_r);
  assign grf_waddr = AW'(used[CW-1:0] + grf_wp_r);

  // Transmit drain, isochronous first
  assign sel_iso = lc_r[`LCHP_LC_ITX_EN] && itf_cnt_r != '0;
  assign sel_async = !sel_iso && lc_r[`LCHP_LC_ATX_EN] && atf_cnt_r != '0;
  assign tx_valid = sel_iso || sel_async;
  assign tx_pop = tx_valid && tx_ready;
  assign tx_raddr = sel_iso ? AW'(atf_size + itf_rp_r) : AW'(atf_rp_r);
  assign tx_word = '{iso: sel_iso, data: mem_r[tx_raddr]};

  // Status words
  assign atf_stat = {atf_full, atf_cnt_r == '0, {(30 - CW){1'b0}},
                     CW'(atf_size - atf_cnt_r)};
  assign itf_stat = {itf_full, itf_cnt_r == '0, {(30 - CW){1'b0}},
                     CW'(itf_size - itf_cnt_r)};
  assign grf_stat = {grf_vis_r == '0, {(31 - 2 * CW){1'b0}}, grf_tot_r, grf_vis_r};

  // Register read mux
  always_comb begin
    case (addr)
      `LCHP_OFS_LINK_CTRL: rd_nxt = 32'(lc_r);
      `LCHP_OFS_INT_STAT: rd_nxt = 32'(ist_r);
      `LCHP_OFS_INT_MASK: rd_nxt = 32'(imask_r);
      `LCHP_OFS_FIFO_CTRL: rd_nxt = fc_r;
      `LCHP_OFS_ATF_STAT: rd_nxt = atf_stat;
      `LCHP_OFS_ITF_STAT: rd_nxt = itf_stat;
      `LCHP_OFS_GRF_STAT: rd_nxt = grf_stat;
      `LCHP_OFS_GRF_DATA: rd_nxt = grf_pop ? mem_r[grf_raddr] : 32'h0000_0000;
      default: rd_nxt = 32'h0000_0000;
    endcase
    if (!hr) begin
      rd_nxt = rd_r;
    end
  end

  // Control registers; set wins over clear in the status bits
  always_comb begin
    fc_nxt = fc_r;
    lc_nxt = lc_r;
    imask_nxt = imask_r;
    iclr = '0;
    if (hw) begin
      case (addr)
        `LCHP_OFS_FIFO_CTRL: fc_nxt = wdata & ~(32'h1 << `LCHP_FC_CLR_BIT);
        `LCHP_OFS_LINK_CTRL: lc_nxt = wdata[`LCHP_LC_W-1:0];
        `LCHP_OFS_INT_MASK: imask_nxt = wdata[`LCHP_INT_W-1:0];
        `LCHP_OFS_INT_STAT: iclr = wdata[`LCHP_INT_W-1:0];
        default: ;
      endcase
    end
    iset = '0;
    iset[`LCHP_INT_RXD] = commit;
    iset[`LCHP_INT_ATF_EMPTY] = tx_pop && sel_async && atf_cnt_r == CW'(1) && !atf_push;
    iset[`LCHP_INT_ITF_EMPTY] = tx_pop && sel_iso && itf_cnt_r == CW'(1) && !itf_push;
    ist_nxt = (ist_r & ~iclr) | iset;
  end
  assign o_int_n = ~|(ist_r & imask_r);

  // Receive writer: status quadlet first, then data
  assign blk_mode = !lc_r[`LCHP_LC_PKT_IRQ];
  assign rx_en = rxq.iso ? lc_r[`LCHP_LC_IRX_EN] : lc_r[`LCHP_LC_ARX_EN];
  always_comb begin
    wst_nxt = wst_r;
    grf_we = 1'b0;
    grf_wd = rxq.data;
    rxq_ready = 1'b0;
    commit = 1'b0;
    case (wst_r)
      LCHP_W_IDLE: begin
        if (rxq_valid && !rx_en) begin
          wst_nxt = LCHP_W_DROP;
        end else if (rxq_valid && grf_space) begin
          grf_we = 1'b1;
          grf_wd = 32'({rxq.iso, rxq.err});
          wst_nxt = LCHP_W_DATA;
        end
      end
      LCHP_W_DATA: begin
        if (rxq_valid && grf_space) begin
          grf_we = 1'b1;
          rxq_ready = 1'b1;
          if (rxq.last) begin
            commit = 1'b1;
            wst_nxt = LCHP_W_IDLE;
          end else if (blk_mode && CW'(grf_pend_r + 1'b1) >= blk) begin
            commit = 1'b1;
          end
        end
      end
      LCHP_W_DROP: begin
        if (rxq_valid) begin
          rxq_ready = 1'b1;
          if (rxq.last) begin
            wst_nxt = LCHP_W_IDLE;
          end
        end
      end
      default: wst_nxt = LCHP_W_IDLE;
    endcase
    if (clr) begin
      wst_nxt = LCHP_W_IDLE;
    end
  end

  // Pointers and counts of the three FIFOs
  always_comb begin
    atf_wp_n = atf_wp_r;
    atf_rp_n = atf_rp_r;
    itf_wp_n = itf_wp_r;
    itf_rp_n = itf_rp_r;
    grf_wp_n = grf_wp_r;
    grf_rp_n = grf_rp_r;
    if (atf_push) atf_wp_n = (atf_wp_r + 1'b1 >= atf_size) ? '0 : CW'(atf_wp_r + 1'b1);
    if (itf_push) itf_wp_n = (itf_wp_r + 1'b1 >= itf_size) ? '0 : CW'(itf_wp_r + 1'b1);
    if (tx_pop && sel_async) begin
      atf_rp_n = (atf_rp_r + 1'b1 >= atf_size) ? '0 : CW'(atf_rp_r + 1'b1);
    end
    if (tx_pop && sel_iso) begin
      itf_rp_n = (itf_rp_r + 1'b1 >= itf_size) ? '0 : CW'(itf_rp_r + 1'b1);
    end
    if (grf_we) grf_wp_n = (grf_wp_r + 1'b1 >= grf_size) ? '0 : CW'(grf_wp_r + 1'b1);
    if (grf_pop) grf_rp_n = (grf_rp_r + 1'b1 >= grf_size) ? '0 : CW'(grf_rp_r + 1'b1);
    atf_cnt_n = CW'(atf_cnt_r + CW'(atf_push) - CW'(tx_pop && sel_async));
    itf_cnt_n = CW'(itf_cnt_r + CW'(itf_push) - CW'(tx_pop && sel_iso));
    grf_tot_n = CW'(grf_tot_r + CW'(grf_we) - CW'(grf_pop));
    grf_pend_n = commit ? '0 : CW'(grf_pend_r + CW'(grf_we));
    grf_vis_n = CW'(grf_vis_r - CW'(grf_pop) + (commit ? CW'(grf_pend_r + 1'b1) : '0));
    if (clr) begin
      atf_wp_n = '0;
      atf_rp_n = '0;
      itf_wp_n = '0;
      itf_rp_n = '0;
      grf_wp_n = '0;
      grf_rp_n = '0;
      atf_cnt_n = '0;
      itf_cnt_n = '0;
      grf_tot_n = '0;
      grf_pend_n = '0;
      grf_vis_n = '0;
    end
  end

  // Shared memory writes; regions overlap only when atf_size plus itf_size exceeds MEM_WORDS
  always_comb begin
    mem_nxt = mem_r;
    if (atf_push) mem_nxt[AW'(atf_wp_r)] = wdata;
    if (itf_push) mem_nxt[AW'(atf_size + itf_wp_r)] = wdata;
    if (grf_we) mem_nxt[grf_waddr] = grf_wd;
  end

  always_ff @(posedge i_core_clk) begin
    mem_r <= mem_nxt;
    // Only a power-on clears the receive and iso enables
    if (!i_por_n) begin
      lc_r <= `LCHP_LC_RST;
    end else if (!i_rstn) begin
      lc_r <= lc_r & ~(`LCHP_LC_W'(1) << `LCHP_LC_ATX_EN);
    end else begin
      lc_r <= lc_nxt;
    end
    if (!i_rstn) begin
      was_cs_r <= 1'b0;
      ack_r <= 1'b0;
      oe_r <= 1'b0;
      rd_r <= 32'h0000_0000;
      fc_r <= `LCHP_FC_RST;
      ist_r <= `LCHP_INT_RST;
      imask_r <= `LCHP_INT_RST;
      wst_r <= LCHP_W_IDLE;
      {atf_wp_r, atf_rp_r, atf_cnt_r, itf_wp_r, itf_rp_r, itf_cnt_r} <= '0;
      {grf_wp_r, grf_rp_r, grf_tot_r, grf_vis_r, grf_pend_r} <= '0;
    end else begin
      was_cs_r <= !i_cs_n;
      ack_r <= take;
      oe_r <= hr;
      rd_r <= rd_nxt;
      fc_r <= fc_nxt;
      ist_r <= ist_nxt;
      imask_r <= imask_nxt;
      wst_r <= wst_nxt;
      {atf_wp_r, atf_rp_r, atf_cnt_r} <= {atf_wp_n, atf_rp_n, atf_cnt_n};
      {itf_wp_r, itf_rp_r, itf_cnt_r} <= {itf_wp_n, itf_rp_n, itf_cnt_n};
      {grf_wp_r, grf_rp_r, grf_tot_r} <= {grf_wp_n, grf_rp_n, grf_tot_n};
      {grf_vis_r, grf_pend_r} <= {grf_vis_n, grf_pend_n};
    end
  end

  // Link crossings and receive buffer
  lchp_xfer #(.W(TXW)) u_tx_xfer (
    .i_src_clk(i_core_clk),
    .i_src_rstn(i_rstn),
    .i_src_data(tx_word),
    .i_src_valid(tx_valid),
    .o_src_ready(tx_ready),
    .i_dst_clk(i_link_clk),
    .i_dst_rstn(i_link_rstn),
    .o_dst_data(o_tx_word),
    .o_dst_valid(o_tx_valid),
    .i_dst_ready(i_tx_ready)
  );
  lchp_xfer #(.W(RXW)) u_rx_xfer (
    .i_src_clk(i_link_clk),
    .i_src_rstn(i_link_rstn),
    .i_src_data(i_rx_word),
    .i_src_valid(i_rx_valid),
    .o_src_ready(o_rx_ready),
    .i_dst_clk(i_core_clk),
    .i_dst_rstn(i_rstn),
    .o_dst_data(rxx_data),
    .o_dst_valid(rxx_valid),
    .i_dst_ready(rxx_ready)
  );
  lchp_fifo #(.W(RXW), .DEPTH(RX_BUF_DEPTH)) u_rx_buf (
    .i_clk(i_core_clk),
    .i_rstn(i_rstn),
    .i_in_data(rxx_data),
    .i_in_valid(rxx_valid),
    .o_in_ready(rxx_ready),
    .o_out_data(rxq),
    .o_out_valid(rxq_valid),
    .i_out_ready(rxq_ready)
  );

  // Checks
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_rstn);
  a_ack_after_take: assert property (take |=> !o_cycle_ack_n)
    else $error("ack missing after taken access");
  a_burst_rate: assert property ((!i_cs_n && is_fifo)[*2]
    |=> !o_cycle_ack_n && !$past(o_cycle_ack_n))
    else $error("burst not one quadlet per clock");
  a_stat_read_seq: assert property ((hr && addr == `LCHP_OFS_GRF_STAT) ##1 i_cs_n
    |-> !o_cycle_ack_n && o_host_data_oe ##1 o_cycle_ack_n && !o_host_data_oe)
    else $error("status read not address, data, idle");
  a_int_assert: assert property ((commit && imask_r[`LCHP_INT_RXD]) |=> !o_int_n)
    else $error("unmasked interrupt not driven low");
  a_clear_empty: assert property (clr |=> atf_cnt_r == '0 && itf_cnt_r == '0
    && grf_tot_r == '0)
    else $error("clear left data in a FIFO");
  a_full_hold: assert property ((hw && addr == `LCHP_OFS_ATF_DATA && atf_full
    && !tx_pop && !clr) |=> atf_cnt_r == $past(atf_cnt_r))
    else $error("write into full transmit FIFO stored");
  a_vis_bound: assert property (grf_vis_r <= grf_tot_r && grf_tot_r <= grf_size)
    else $error("receive counts out of range");
  a_pkt_irq: assert property ((commit && !blk_mode) |-> rxq.last)
    else $error("packet mode fired before packet end");
  a_status_first: assert property ((wst_r == LCHP_W_IDLE && grf_we && !clr)
    |=> wst_r == LCHP_W_DATA && grf_pend_r == CW'(1))
    else $error("status quadlet not stored first");
  a_rst_atx: assert property (@(posedge i_core_clk) disable iff (!i_por_n)
    !i_rstn |=> !lc_r[`LCHP_LC_ATX_EN])
    else $error("reset left async transmit enabled");
  c_burst: cover property ((!i_cs_n && is_fifo && !i_wr_n)[*3]);
  c_block_irq: cover property (commit && blk_mode && !rxq.last);
  c_pkt_irq: cover property (commit && rxq.last);
  c_tx_drain: cover property (tx_pop && sel_iso ##1 tx_pop && sel_async);
endmodule
`default_nettype wire

/* lchp_link_model.sv */
// Link-side model: takes transmit words with stalls, sends receive packets
`timescale 1ns/1ns
`default_nettype none
module lchp_link_model (
  // Link clock and reset
  input wire logic i_link_clk,
  input wire logic i_link_rstn,
  // Words toward the port
  output lchp_pkg::lchp_rx_word_t o_rx_word,
  output logic o_rx_valid,
  input wire logic i_rx_ready,
  // Words from the port
  input wire lchp_pkg::lchp_tx_word_t i_tx_word,
  input wire logic i_tx_valid,
  output logic o_tx_ready
);
  import lchp_pkg::*;
  lchp_tx_word_t tq[$];
  initial begin
    o_rx_word = '0;
    o_rx_valid = 1'b0;
  end
  // Ready every other cycle so the port must hold its word
  always @(posedge i_link_clk) begin
    if (!i_link_rstn) begin
      o_tx_ready <= 1'b0;
    end else begin
      o_tx_ready <= ~o_tx_ready;
      if (i_tx_valid && o_tx_ready) begin
        tq.push_back(i_tx_word);
      end
    end
  end
  task automatic send(input int n, input logic [3:0] err, input logic [31:0] d);
    for (int k = 0; k < n; k++) begin
      @(posedge i_link_clk);
      o_rx_valid <= 1'b1;
      o_rx_word <= '{iso: 1'b0, last: (k == n - 1), err: err, data: d + k};
      do @(posedge i_link_clk); while (!i_rx_ready);
      o_rx_valid <= 1'b0;
      o_rx_word <= ~o_rx_word;
    end
  endtask
endmodule
`default_nettype wire

/* lchp_pkg.sv */
// Types shared by the host port and its link side
package lchp_pkg;
  typedef struct packed {
    logic iso;
    logic last;
    logic [3:0] err;
    logic [31:0] data;
  } lchp_rx_word_t;
  typedef struct packed {
    logic iso;
    logic [31:0] data;
  } lchp_tx_word_t;
  typedef enum logic [1:0] {
    LCHP_W_IDLE = 2'b00,
    LCHP_W_DATA = 2'b01,
    LCHP_W_DROP = 2'b11
  } lchp_wr_state_t;
endpackage

/* lchp_regs.svh */
// Register offsets, field positions, reset values and sizes of the host port
`ifndef LCHP_REGS_SVH
`define LCHP_REGS_SVH
`define LCHP_OFS_LINK_CTRL 8'h08
`define LCHP_OFS_INT_STAT 8'h0C
`define LCHP_OFS_INT_MASK 8'h10
`define LCHP_OFS_FIFO_CTRL 8'h1C
`define LCHP_OFS_ATF_STAT 8'h30
`define LCHP_OFS_ITF_STAT 8'h34
`define LCHP_OFS_GRF_STAT 8'h3C
`define LCHP_OFS_ATF_DATA 8'h80
`define LCHP_OFS_ITF_DATA 8'h84
`define LCHP_OFS_GRF_DATA 8'hC0
`define LCHP_FC_ATF_LSB 0
`define LCHP_FC_ITF_LSB 10
`define LCHP_FC_BLK_LSB 20
`define LCHP_FC_CLR_BIT 31
`define LCHP_FC_RST 32'h0102_0080
`define LCHP_LC_ATX_EN 0
`define LCHP_LC_ITX_EN 1
`define LCHP_LC_ARX_EN 2
`define LCHP_LC_IRX_EN 3
`define LCHP_LC_PKT_IRQ 4
`define LCHP_LC_W 5
`define LCHP_LC_RST 5'h00
`define LCHP_INT_RXD 0
`define LCHP_INT_ATF_EMPTY 1
`define LCHP_INT_ITF_EMPTY 2
`define LCHP_INT_W 3
`define LCHP_INT_RST 3'h0
`define LCHP_MEM_BYTES 2048
`define LCHP_MEM_WORDS (`LCHP_MEM_BYTES / 4)
`define LCHP_RX_BUF_DEPTH 8
`endif

/* lchp_xfer.sv */
// Toggle handshake carrying one word at a time between two clocks
`timescale 1ns/1ns
`default_nettype none
module lchp_xfer #(
  parameter int W = 8
) (
  // Source domain
  input wire logic i_src_clk,
  input wire logic i_src_rstn,
  input wire logic [W-1:0] i_src_data,
  input wire logic i_src_valid,
  output logic o_src_ready,
  // Destination domain
  input wire logic i_dst_clk,
  input wire logic i_dst_rstn,
  output logic [W-1:0] o_dst_data,
  output logic o_dst_valid,
  input wire logic i_dst_ready
);
  logic req_r, req_nxt, ack_lvl_r, ack_lvl_nxt;
  logic [W-1:0] data_r, data_nxt;
  logic [2:0] ack_s_r;
  logic ack_r, ack_nxt, req_lvl_r, req_lvl_nxt;
  logic [2:0] req_s_r;

  // Source side
  assign o_src_ready = ack_lvl_r == req_r;
  always_comb begin
    req_nxt = req_r;
    data_nxt = data_r;
    if (i_src_valid && o_src_ready) begin
      req_nxt = ~req_r;
      data_nxt = i_src_data;
    end
    ack_lvl_nxt = (ack_s_r[1] == ack_s_r[2]) ? ack_s_r[2] : ack_lvl_r;
  end
  always_ff @(posedge i_src_clk) begin
    if (!i_src_rstn) begin
      req_r <= 1'b0;
      data_r <= '0;
      ack_s_r <= 3'h0;
      ack_lvl_r <= 1'b0;
    end else begin
      req_r <= req_nxt;
      data_r <= data_nxt;
      ack_s_r <= {ack_s_r[1:0], ack_r};
      ack_lvl_r <= ack_lvl_nxt;
    end
  end

  // Destination side; data stays put until the ack returns
  assign o_dst_valid = req_lvl_r != ack_r;
  assign o_dst_data = data_r;
  always_comb begin
    ack_nxt = (o_dst_valid && i_dst_ready) ? ~ack_r : ack_r;
    req_lvl_nxt = (req_s_r[1] == req_s_r[2]) ? req_s_r[2] : req_lvl_r;
  end
  always_ff @(posedge i_dst_clk) begin
    if (!i_dst_rstn) begin
      ack_r <= 1'b0;
      req_s_r <= 3'h0;
      req_lvl_r <= 1'b0;
    end else begin
      ack_r <= ack_nxt;
      req_s_r <= {req_s_r[1:0], req_r};
      req_lvl_r <= req_lvl_nxt;
    end
  end
endmodule
`default_nettype wire

/* link_ctrl_host_bus_port_test.sv */
// Host bus testbench for the host port, with a link-side model
`timescale 1ns/1ns
`default_nettype none
`include "lchp_regs.svh"
module link_ctrl_host_bus_port_test;
  import lchp_pkg::*;
  logic i_core_clk = 1'b0;
  logic i_link_clk = 1'b0;
  logic i_rstn = 1'b0;
  logic i_link_rstn = 1'b0;
  logic por_n = 1'b0;
  logic cs_n = 1'b1;
  logic wr_n = 1'b1;
  logic [7:0] adr = 8'h00;
  logic [31:0] wd = 32'h0;
  logic [31:0] rd;
  logic oe, ack_n, int_n, rx_valid, rx_ready, tx_valid, tx_ready;
  lchp_rx_word_t rx_word;
  lchp_tx_word_t tx_word;
  logic [31:0] rq[0:7];
  int mismatches = 0;
  int num_checks = 0;
  lchp_host_port i_lchp_host_port (.i_core_clk(i_core_clk), .i_rstn(i_rstn),
    .i_por_n(por_n), .i_cs_n(cs_n), .i_wr_n(wr_n), .i_host_address_lines(adr),
    .i_host_data(wd), .o_host_data(rd), .o_host_data_oe(oe), .o_cycle_ack_n(ack_n),
    .o_int_n(int_n), .i_link_clk(i_link_clk), .i_link_rstn(i_link_rstn),
    .i_rx_word(rx_word), .i_rx_valid(rx_valid), .o_rx_ready(rx_ready),
    .o_tx_word(tx_word), .o_tx_valid(tx_valid), .i_tx_ready(tx_ready));
  lchp_link_model i_lchp_link_model (.i_link_clk(i_link_clk), .i_link_rstn(i_link_rstn),
    .o_rx_word(rx_word), .o_rx_valid(rx_valid), .i_rx_ready(rx_ready),
    .i_tx_word(tx_word), .i_tx_valid(tx_valid), .o_tx_ready(tx_ready));
  initial begin
    forever #2 i_core_clk = ~i_core_clk;
  end
  initial begin
    #7;
    forever #32 i_link_clk = ~i_link_clk;
  end
  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // One access or a burst of n quadlets, then one idle cycle
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, input int n);
    for (int i = 0; i <= n; i++) begin
      @(posedge i_core_clk);
      cs_n <= (i == n);
      wr_n <= ~w;
      adr <= a;
      wd <= d + i;
      if (i > 0) begin
        #1;
        chk("ack", {31'h0, ack_n}, 32'h0);
        chk("oe", {31'h0, oe}, {31'h0, !w});
        if (!w) begin
          rq[i - 1] = rd;
        end
      end
    end
    @(posedge i_core_clk);
    #1;
    chk("idle ack", {31'h0, ack_n}, 32'h1);
    chk("idle oe", {31'h0, oe}, 32'h0);
  endtask
  task automatic wait_tx(input int n);
    for (int t = 0; t < 3000 && i_lchp_link_model.tq.size() < n; t++) begin
      @(posedge i_core_clk);
    end
    chk("tx count", i_lchp_link_model.tq.size(), n);
  endtask
  task automatic close_out();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  initial begin
    #200000;
    mismatches++;
    close_out();
  end
  initial begin
    repeat (4) @(posedge i_link_clk);
    i_link_rstn <= 1'b1;
    repeat (8) @(posedge i_core_clk);
    i_rstn <= 1'b1;
    por_n <= 1'b1;
    bus(0, `LCHP_OFS_FIFO_CTRL, 0, 1);
    chk("fifo ctrl", rq[0], 32'h0102_0080);
    bus(0, `LCHP_OFS_LINK_CTRL, 0, 1);
    chk("atx en", rq[0] & 32'h1, 32'h0);
    bus(0, `LCHP_OFS_ATF_STAT, 0, 1);
    chk("atf st", rq[0] & 32'hC000_03FF, 32'h4000_0080);
    bus(0, `LCHP_OFS_ITF_STAT, 0, 1);
    chk("itf st", rq[0] & 32'hC000_03FF, 32'h4000_0080);
    bus(1, `LCHP_OFS_GRF_STAT, 32'hFFFF_FFFF, 1);
    bus(0, `LCHP_OFS_GRF_STAT, 0, 1);
    chk("grf st", rq[0] & 32'h8000_03FF, 32'h8000_0000);
    bus(0, 8'h40, 0, 1);
    chk("unmapped", rq[0], 32'h0);
    bus(1, `LCHP_OFS_ATF_DATA, 32'h1234_5600, 3);
    bus(0, `LCHP_OFS_ATF_STAT, 0, 1);
    chk("atf 3", rq[0] & 32'hC000_03FF, 32'h0000_007D);
    bus(1, `LCHP_OFS_FIFO_CTRL, 32'h8102_0002, 1);
    bus(0, `LCHP_OFS_ATF_STAT, 0, 1);
    chk("atf clr", rq[0] & 32'hC000_03FF, 32'h4000_0002);
    bus(1, `LCHP_OFS_ATF_DATA, 32'h0000_00A0, 3);
    bus(0, `LCHP_OFS_ATF_STAT, 0, 1);
    chk("atf full", rq[0] & 32'hC000_03FF, 32'h8000_0000);
    bus(1, `LCHP_OFS_LINK_CTRL, 32'h2, 1);
    bus(1, `LCHP_OFS_ITF_DATA, 32'h8000_0001, 3);
    wait_tx(3);
    bus(1, `LCHP_OFS_LINK_CTRL, 32'h17, 1);
    wait_tx(5);
    for (int i = 0; i < 5; i++) begin
      chk("tx iso", {31'h0, i_lchp_link_model.tq[i].iso}, {31'h0, i < 3});
      chk("tx data", i_lchp_link_model.tq[i].data,
        (i < 3) ? 32'h8000_0001 + i : 32'hA0 + i - 3);
    end
    i_lchp_link_model.send(2, 4'h5, 32'hCAFE_0000);
    for (int t = 0; t < 50; t++) begin
      bus(0, `LCHP_OFS_GRF_STAT, 0, 1);
      if (rq[0][31] === 1'b0) break;
    end
    chk("grf next", rq[0] & 32'h8000_03FF, 32'h3);
    chk("int masked", {31'h0, int_n}, 32'h1);
    bus(0, `LCHP_OFS_INT_STAT, 0, 1);
    chk("rx irq", rq[0] & 32'h1, 32'h1);
    bus(1, `LCHP_OFS_INT_MASK, 32'h1, 1);
    chk("int on", {31'h0, int_n}, 32'h0);
    bus(1, `LCHP_OFS_INT_STAT, 32'h1, 1);
    chk("int off", {31'h0, int_n}, 32'h1);
    bus(0, `LCHP_OFS_GRF_DATA, 0, 3);
    chk("rx status", rq[0], 32'h5);
    chk("rx d0", rq[1], 32'hCAFE_0000);
    chk("rx d1", rq[2], 32'hCAFE_0001);
    bus(0, `LCHP_OFS_GRF_STAT, 0, 1);
    chk("grf empty", rq[0] & 32'h8000_0000, 32'h8000_0000);
    // Mid-run reset of both domains, power-on held off
    bus(1, `LCHP_OFS_LINK_CTRL, 32'hF, 1);
    i_rstn <= 1'b0;
    i_link_rstn <= 1'b0;
    repeat (4) @(posedge i_link_clk);
    i_link_rstn <= 1'b1;
    @(posedge i_core_clk);
    i_rstn <= 1'b1;
    bus(0, `LCHP_OFS_LINK_CTRL, 0, 1);
    chk("rst keeps en", rq[0], 32'h0000_000E);
    // Receive disabled: packet must be dropped
    bus(1, `LCHP_OFS_LINK_CTRL, 32'h0, 1);
    i_lchp_link_model.send(1, 4'h3, 32'h0);
    repeat (64) @(posedge i_core_clk);
    bus(0, `LCHP_OFS_GRF_STAT, 0, 1);
    chk("rx dropped", rq[0] & 32'h800F_FFFF, 32'h8000_0000);
    close_out();
  end
endmodule
`default_nettype wire
